// *** include/boot_menu_pkg.sv ***
// boot_menu_pkg: constants, register map, texts and types of the boot menu
// assumes a 250 MHz core clock; included before every design file
package boot_menu_pkg;
  // ----------------------------------------
  // clock and line rates
  // ----------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_MHZ = 250;
  localparam int BAUD_FAST = 115200;
  localparam int BAUD_SLOW = 9600;
  localparam int DIV_FAST = CLK_HZ / BAUD_FAST;
  localparam int DIV_SLOW = CLK_HZ / BAUD_SLOW;
  // a fast start-bit run never exceeds nine fast bits, ten with even parity
  localparam int AUTO_SPLIT = (9 * DIV_FAST + DIV_SLOW) / 2;
  // nak base times in microseconds, then in cycles
  localparam int BASE_LOCAL_US = 1000;
  localparam int BASE_OTA_US = 4000;
  localparam int BASE_LOCAL_CYC = BASE_LOCAL_US * CLK_MHZ;
  localparam int BASE_OTA_CYC = BASE_OTA_US * CLK_MHZ;
  localparam logic [3:0] NAK_EXP_RESET = 4'h0;
  localparam logic [3:0] NAK_EXP_MAX = 4'hF;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TIMEOUT = 8'h08;
  localparam logic [7:0] REG_EVENT = 8'h0C;
  localparam logic [7:0] REG_APPVER = 8'h10;
  localparam logic [7:0] REG_CAPS = 8'h14;
  localparam int EV_REPEAT = 0;
  localparam int EV_NAKFAIL = 1;
  localparam int EV_DONE = 2;
  localparam int EV_FERR_CLR = 3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [31:0] APPVER_RESET = 32'h0;
  localparam logic [7:0] PAYLOAD_PREF = 8'h40;
  localparam logic [7:0] PAYLOAD_MAX = 8'h80;
  // ----------------------------------------
  // characters
  // ----------------------------------------
  localparam logic [7:0] CMD_BYPASS = 8'h42;
  localparam logic [7:0] CMD_UPDATE = 8'h46;
  localparam logic [7:0] CMD_TIMEOUT = 8'h54;
  localparam logic [7:0] CMD_APPVER = 8'h41;
  localparam logic [7:0] CMD_BLVER = 8'h56;
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_C = 8'h43;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_NINE = 8'h39;
  // ----------------------------------------
  // response texts; hardware and version fields are arbitrary
  // ----------------------------------------
  localparam int TEXT_LEN = 72;
  localparam logic [8*TEXT_LEN-1:0] TEXT = {
    "\r\nB=bypass F=update T=timeout A=app V=boot\r\n>",
    "BL032-0A0-001_064\r\n",
    "Unkown\r\n"};
  localparam logic [6:0] MENU_OFS = 7'h00;
  localparam logic [6:0] VERS_OFS = 7'h2D;
  localparam logic [6:0] UNK_OFS = 7'h40;
  localparam logic [6:0] TEXT_END = 7'h48;
  localparam logic [6:0] APP_LEN = 7'h04;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum {ST_MENU, ST_SEND, ST_TDIGIT, ST_REQ_C, ST_XFER, ST_BYPASS,
    ST_RUN_APP} menu_state_type;
  typedef struct packed {
    logic app_present;
    logic two_stop;
    logic [1:0] parity;
    logic rate_slow;
  } cfg_type;
  typedef struct packed {
    logic valid;
    logic unicast;
    logic [7:0] len;
    logic [7:0] data;
  } ota_cmd_type;
endpackage : boot_menu_pkg

// *** src/text_rom.sv ***
// text_rom: response texts, one byte per address, registered read data
// assumes the address stays below the text length
`timescale 1ns/1ps
`default_nettype none
module text_rom
  import boot_menu_pkg::*;
#(
  parameter int DEPTH = TEXT_LEN,
  parameter logic [8*DEPTH-1:0] CONTENT = TEXT
) (
  // clock
  input wire logic core_clk,
  // read port
  input wire logic [6:0] addr,
  output logic [7:0] data
);
  // the first character sits in the top byte of the constant
  always_ff @(posedge core_clk) begin
    data <= CONTENT[8*(DEPTH-1-int'(addr)) +: 8];
  end
endmodule : text_rom
`default_nettype wire

// *** src/boot_menu_command_uart.sv ***
// boot_menu_command_uart: boot menu command interpreter with local serial port
// assumes ota commands arrive already parsed on core_clk; apb slave for setup
//
// Summary of operation
// [R1] commands come from the local serial port or from radio packets alike
// [R2] radio commands count only when unicast with exactly one payload byte
// [R3] each response goes back to the source of its command
// [R4] bypass joins local serial port to radio serial channel both ways
// [R5] bypass passes any line rate without configuration
// [R6] bypass is refused when it arrives over the radio
// [R7] bypass ends only by reset
// [R8] download runs over the path its command came from
// [R9] nak wait is base time shifted by exponent; base per path
// [R10] repeats or failed naks during download raise the exponent
// [R11] app version text, or a fixed unknown text without application
// [R12] boot version text holds flash size, hardware, version, payload size
// [R13] downloader takes 64-byte payloads, maybe 128-byte payloads
// [R14] radio link and local port default to 115200 baud
// [R15] local port switches between 115200 and 9600 after one character
// [R16] carriage return sends the menu text to the requester
// [R17] during download start the character C repeats until data arrives
// [R18] after a finished download the application is started
// [R19] a wired host uses 115200 baud, 8 data bits, no parity, 1 stop
// [R20] the sender strips fill bytes from its flat binary image
// [R21] an idle serial line stays high
// [R22] a character is low start, 8 data bits lsb first, high stop
// [R23] line rate, parity and stop count are settable
// [R24] receiver samples mid-bit, resyncs on start edge, flags framing errors
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module boot_menu_command_uart
  import boot_menu_pkg::*;
#(
  parameter int SLOW_DIV = DIV_SLOW,
  parameter int LOCAL_BASE = BASE_LOCAL_CYC,
  parameter int OTA_BASE = BASE_OTA_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // local serial port and radio serial channel
  input wire logic local_rxd,
  output logic local_txd,
  input wire logic radio_rxd,
  output logic radio_txd,
  // radio packets in and responses out
  input wire ota_cmd_type ota_in,
  output logic ota_tx_valid,
  output logic [7:0] ota_tx_byte,
  input wire logic ota_tx_ready,
  // downloader side
  output logic dl_active,
  output logic dl_from_ota,
  output logic dl_byte_valid,
  output logic [7:0] dl_byte,
  output logic [39:0] dl_timeout,
  output logic run_app
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  menu_state_type state;
  cfg_type cfg;
  logic loc_s1, loc_s2, rad_s1, rad_s2, rx_prev;
  logic rx_busy, rx_done, ferr, run_armed;
  logic [15:0] rx_cnt, lo_run, tx_cnt;
  logic [3:0] rx_bit, tx_left, nak_exp;
  logic [8:0] rx_sh;
  logic [7:0] rx_byte;
  logic [11:0] tx_sh;
  logic [6:0] snd_ptr, snd_end;
  logic snd_app, snd_wait, src_ota;
  logic [39:0] nak_tmr;
  logic [31:0] app_ver;
  logic [7:0] rom_q;
  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire [15:0] bit_div = cfg.rate_slow ? 16'(SLOW_DIV) : 16'(DIV_FAST);
  wire par_on = cfg.parity != PAR_NONE;
  wire [3:0] stop_idx = par_on ? 4'hA : 4'h9;
  wire rx_tick = rx_busy && rx_cnt == 16'h0;
  wire rx_at_stop = rx_tick && rx_bit == stop_idx;
  wire fall = rx_prev && !loc_s2;
  wire rise = !rx_prev && loc_s2;
  wire tx_busy = tx_left != 4'h0;
  wire wr_en = psel && penable && pwrite && pready;
  wire ev_wr = wr_en && paddr == REG_EVENT;
  wire ev_repeat = ev_wr && pwdata[EV_REPEAT];
  wire ev_nakfail = ev_wr && pwdata[EV_NAKFAIL];
  wire ev_done = ev_wr && pwdata[EV_DONE];
  wire loc_cmd = rx_done && state != ST_BYPASS;
  wire ota_ok = ota_in.valid && ota_in.unicast && ota_in.len == 8'h01; // R2
  wire cmd_valid = loc_cmd || ota_ok; // R1
  wire cmd_ota = !loc_cmd;
  wire [7:0] cmd_byte = loc_cmd ? rx_byte : ota_in.data;
  wire ota_any = ota_in.valid && ota_in.unicast;
  wire xfer_in = src_ota ? ota_any : loc_cmd;
  wire out_busy = src_ota ? ota_tx_valid : tx_busy;
  wire [39:0] nak_wait = (src_ota ? 40'(OTA_BASE) : 40'(LOCAL_BASE)) << nak_exp; // R9
  wire c_due = state == ST_REQ_C && nak_tmr == 40'h0 && !out_busy; // R17
  wire snd_go = state == ST_SEND && !snd_wait && snd_ptr != snd_end && !out_busy;
  wire launch = c_due || snd_go;
  wire [7:0] app_chr = app_ver[8*int'(snd_ptr[1:0]) +: 8];
  wire [7:0] out_byte = c_due ? CHR_C : snd_app ? app_chr : rom_q;
  wire tx_load = launch && !src_ota; // R3
  wire pbit = (^out_byte) ^ (cfg.parity == PAR_ODD);
  wire [11:0] frame = par_on ? {2'b11, pbit, out_byte, 1'b0}
                             : {3'b111, out_byte, 1'b0}; // R22
  wire [3:0] frame_len = 4'hA + {3'h0, par_on} + {3'h0, cfg.two_stop}; // R23
  wire is_digit = cmd_byte >= CHR_ZERO && cmd_byte <= CHR_NINE;
  wire [7:0] digit = cmd_byte - CHR_ZERO;
  // ----------------------------------------
  // input synchronisers; idle lines reset high
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {loc_s1, loc_s2, rad_s1, rad_s2, rx_prev} <= 5'h1F;
    end else begin
      {loc_s1, loc_s2} <= {local_rxd, loc_s1};
      {rad_s1, rad_s2} <= {radio_rxd, rad_s1};
      rx_prev <= loc_s2;
    end
  end
  // ----------------------------------------
  // receiver: half-bit delay from the start edge centres each sample
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_busy <= 1'b0;
      rx_cnt <= 16'h0;
      rx_bit <= 4'h0;
      rx_sh <= 9'h0;
    end else if (!rx_busy) begin
      if (fall) begin
        rx_busy <= 1'b1; // R24
        rx_cnt <= bit_div >> 1;
        rx_bit <= 4'h0;
      end
    end else if (!rx_tick) begin
      rx_cnt <= rx_cnt - 16'h1;
    end else begin
      rx_cnt <= bit_div - 16'h1;
      rx_bit <= rx_bit + 4'h1;
      rx_sh <= {loc_s2, rx_sh[8:1]};
      // a start bit gone high again was a glitch
      if ((rx_bit == 4'h0 && loc_s2) || rx_at_stop) begin
        rx_busy <= 1'b0;
      end
    end
  end
  // received byte and framing error; the set wins over a clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_done <= 1'b0;
      rx_byte <= 8'h0;
      ferr <= 1'b0;
    end else begin
      rx_done <= rx_at_stop && loc_s2;
      if (rx_at_stop) begin
        rx_byte <= par_on ? rx_sh[7:0] : rx_sh[8:1];
      end
      if (rx_at_stop && !loc_s2) begin
        ferr <= 1'b1; // R24
      end else if (ev_wr && pwdata[EV_FERR_CLR]) begin
        ferr <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // line rate detection from the length of the first low run
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lo_run <= 16'h0;
      run_armed <= 1'b0;
    end else begin
      lo_run <= loc_s2 ? 16'h0 : lo_run + {15'h0, lo_run != 16'hFFFF};
      if (fall) begin
        run_armed <= !rx_busy;
      end else if (rise) begin
        run_armed <= 1'b0;
      end
    end
  end
  // configuration: software writes, detection sets the rate bit; a config or app version write in the same cycle wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg <= '0; // R14
      app_ver <= APPVER_RESET;
    end else if (wr_en && paddr == REG_CONFIG) begin
      cfg <= pwdata[4:0]; // R23
    end else if (wr_en && paddr == REG_APPVER) begin
      app_ver <= pwdata;
    end else if (rise && run_armed) begin
      if (lo_run >= 16'(AUTO_SPLIT)) begin
        cfg.rate_slow <= 1'b1; // R15
      end else if (lo_run < 16'(SLOW_DIV / 2)) begin
        cfg.rate_slow <= 1'b0; // R15
      end
    end
  end
  // ----------------------------------------
  // transmitter: shifts ones in behind the frame, so idle is high
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_sh <= 12'hFFF; // R21
      tx_left <= 4'h0;
      tx_cnt <= 16'h0;
    end else if (tx_load) begin
      tx_sh <= frame;
      tx_left <= frame_len;
      tx_cnt <= bit_div - 16'h1;
    end else if (tx_busy && tx_cnt == 16'h0) begin
      tx_sh <= {1'b1, tx_sh[11:1]};
      tx_left <= tx_left - 4'h1;
      tx_cnt <= bit_div - 16'h1;
    end else if (tx_busy) begin
      tx_cnt <= tx_cnt - 16'h1;
    end
  end
  // pin drivers: bypass copies the synchronised lines, so any rate passes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      local_txd <= 1'b1;
      radio_txd <= 1'b1;
    end else begin
      local_txd <= state == ST_BYPASS ? rad_s2 : tx_sh[0]; // R4 R5
      radio_txd <= state == ST_BYPASS ? loc_s2 : 1'b1; // R4
    end
  end
  // ----------------------------------------
  // response text source
  // ----------------------------------------
  text_rom u_text (
    .core_clk(core_clk),
    .addr(snd_ptr),
    .data(rom_q)
  );
  // ----------------------------------------
  // menu state machine
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_MENU;
      src_ota <= 1'b0;
      snd_ptr <= 7'h0;
      snd_end <= 7'h0;
      snd_app <= 1'b0;
      snd_wait <= 1'b0;
      nak_tmr <= 40'h0;
    end else begin
      snd_wait <= launch;
      if (launch) begin
        snd_ptr <= snd_ptr + 7'h1;
      end
      unique case (state)
        ST_MENU: begin
          if (cmd_valid) begin
            src_ota <= cmd_ota; // R3
            snd_wait <= 1'b1;
            snd_app <= 1'b0;
            if (cmd_byte == CHR_CR) begin
              state <= ST_SEND; // R16
              snd_ptr <= MENU_OFS;
              snd_end <= VERS_OFS;
            end else if (cmd_byte == CMD_BYPASS && !cmd_ota) begin
              state <= ST_BYPASS; // R6
            end else if (cmd_byte == CMD_UPDATE) begin
              state <= ST_REQ_C; // R8
              nak_tmr <= 40'h0;
            end else if (cmd_byte == CMD_TIMEOUT) begin
              state <= ST_TDIGIT;
            end else if (cmd_byte == CMD_APPVER) begin
              state <= ST_SEND; // R11
              snd_app <= cfg.app_present;
              snd_ptr <= cfg.app_present ? 7'h0 : UNK_OFS;
              snd_end <= cfg.app_present ? APP_LEN : TEXT_END;
            end else if (cmd_byte == CMD_BLVER) begin
              state <= ST_SEND; // R12
              snd_ptr <= VERS_OFS;
              snd_end <= UNK_OFS;
            end
          end
        end
        ST_SEND: begin
          if (snd_ptr == snd_end && !out_busy && !snd_wait) begin
            state <= ST_MENU;
          end
        end
        ST_TDIGIT: begin
          if (cmd_valid) begin
            state <= ST_MENU;
          end
        end
        ST_REQ_C: begin
          if (xfer_in) begin
            state <= ST_XFER; // R17
          end else if (launch) begin
            nak_tmr <= nak_wait;
          end else if (nak_tmr != 40'h0) begin
            nak_tmr <= nak_tmr - 40'h1;
          end
        end
        ST_XFER: begin
          if (ev_done) begin
            state <= ST_RUN_APP; // R18
          end
        end
        ST_BYPASS: begin
          state <= ST_BYPASS; // R7
        end
        ST_RUN_APP: begin
          state <= ST_RUN_APP;
        end
      endcase
    end
  end
  // nak exponent: digit after the timeout command, software, or growth
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nak_exp <= NAK_EXP_RESET;
    end else if (state == ST_TDIGIT && cmd_valid && is_digit) begin
      nak_exp <= digit[3:0]; // R9
    end else if (wr_en && paddr == REG_TIMEOUT) begin
      nak_exp <= pwdata[3:0];
    end else if (state == ST_XFER && (ev_repeat || ev_nakfail)
                 && nak_exp != NAK_EXP_MAX) begin
      nak_exp <= nak_exp + 4'h1; // R10
    end
  end
  // ----------------------------------------
  // outputs toward the radio and the downloader
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ota_tx_valid <= 1'b0;
      ota_tx_byte <= 8'h0;
      dl_active <= 1'b0;
      dl_from_ota <= 1'b0;
      dl_byte_valid <= 1'b0;
      dl_byte <= 8'h0;
      dl_timeout <= 40'h0;
      run_app <= 1'b0;
    end else begin
      if (launch && src_ota) begin
        ota_tx_valid <= 1'b1; // R3
        ota_tx_byte <= out_byte;
      end else if (ota_tx_ready) begin
        ota_tx_valid <= 1'b0;
      end
      dl_active <= state == ST_XFER;
      dl_from_ota <= src_ota; // R8
      dl_byte_valid <= (state == ST_REQ_C || state == ST_XFER) && xfer_in;
      dl_byte <= src_ota ? ota_in.data : rx_byte;
      dl_timeout <= nak_wait;
      run_app <= state == ST_RUN_APP;
    end
  end
  // ----------------------------------------
  // apb slave: answers in the first access cycle
  // ----------------------------------------
  wire [7:0] st_code = 8'(state);
  wire mapped = paddr <= REG_CAPS && paddr[1:0] == 2'h0;
  wire [31:0] rd_mux =
    paddr == REG_CONFIG ? {27'h0, cfg} :
    paddr == REG_STATUS ? {21'h0, ferr, cfg.rate_slow, src_ota, st_code} :
    paddr == REG_TIMEOUT ? {28'h0, nak_exp} :
    paddr == REG_APPVER ? app_ver :
    paddr == REG_CAPS ? {16'h0, PAYLOAD_MAX, PAYLOAD_PREF} : 32'h0; // R13
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= rd_mux;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_local_load;
    tx_load && state != ST_BYPASS;
  endsequence
  a_ota_filter: assert property (@(posedge core_clk) disable iff (rst) // R2
    state == ST_MENU && !loc_cmd && ota_in.valid && !ota_ok |=> state == ST_MENU)
    else $error("bad radio packet acted on");
  a_bypass_remote: assert property (@(posedge core_clk) disable iff (rst) // R6
    state == ST_MENU && ota_ok && !loc_cmd && ota_in.data == CMD_BYPASS
    |=> state != ST_BYPASS) else $error("bypass taken from radio");
  a_bypass_held: assert property (@(posedge core_clk) disable iff (rst) // R7
    state == ST_BYPASS |=> state == ST_BYPASS) else $error("bypass left");
  a_bypass_copy: assert property (@(posedge core_clk) disable iff (rst) // R4
    state == ST_BYPASS |=> local_txd == $past(rad_s2) && radio_txd == $past(loc_s2))
    else $error("bypass does not copy lines");
  a_start_bit: assert property (@(posedge core_clk) disable iff (rst) // R22
    s_local_load ##1 state != ST_BYPASS |=> !local_txd) else $error("no start bit");
  a_nak_scale: assert property (@(posedge core_clk) disable iff (rst) // R9
    state == ST_REQ_C && launch && !xfer_in |=> nak_tmr == ((src_ota ? 40'(OTA_BASE)
    : 40'(LOCAL_BASE)) << $past(nak_exp))) else $error("wrong nak wait");
  a_nak_grow: assert property (@(posedge core_clk) disable iff (rst) // R10
    state == ST_XFER && ev_repeat && nak_exp != NAK_EXP_MAX
    |=> nak_exp == $past(nak_exp) + 4'h1) else $error("nak wait not raised");
  a_jump_app: assert property (@(posedge core_clk) disable iff (rst) // R18
    state == ST_XFER && ev_done |=> ##1 run_app) else $error("no application start");
  a_ferr_set: assert property (@(posedge core_clk) disable iff (rst) // R24
    rx_at_stop && !loc_s2 |=> ferr) else $error("framing error lost");
endmodule : boot_menu_command_uart
`default_nettype wire

// *** tb/host_model.sv ***
// host_model: serial terminal on the local port and remote node on radio
// assumes the bench calls its tasks from one process, right after an edge
`timescale 1ns/1ps
`default_nettype none
module host_model
  import boot_menu_pkg::*;
(
  // clock
  input wire logic core_clk,
  // local serial line
  output logic local_rxd,
  input wire logic local_txd,
  // radio packets and responses
  output ota_cmd_type ota_in,
  input wire logic ota_tx_valid,
  input wire logic [7:0] ota_tx_byte,
  output logic ota_tx_ready
);
  logic [7:0] q[$];
  logic [1:0] pace = 2'h0;
  logic slow = 1'b1;
  initial begin
    local_rxd = 1'b1;
    ota_in = '0;
  end
  // a slow node takes one byte in four cycles, a prompt one every cycle
  assign ota_tx_ready = slow ? pace == 2'h3 : 1'b1;
  always @(posedge core_clk) begin
    pace <= pace + 2'h1;
    if (ota_tx_valid === 1'b1 && ota_tx_ready) q.push_back(ota_tx_byte);
  end
  // low start, eight data lsb first, high stop; idle high afterwards
  task automatic put_char(input logic [7:0] c, input int bit_cyc);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      local_rxd <= f[i];
      repeat (bit_cyc) @(posedge core_clk);
    end
  endtask : put_char
  // waits for a start bit, then samples each bit in its middle
  task automatic get_char(output logic [7:0] c, output logic ok, input int bit_cyc);
    int n;
    n = 0;
    c = 8'h00;
    while (local_txd === 1'b1 && n < 40 * bit_cyc) begin
      @(posedge core_clk);
      n++;
    end
    repeat (bit_cyc / 2) @(posedge core_clk);
    ok = local_txd === 1'b0;
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge core_clk);
      c[i] = local_txd;
    end
    repeat (bit_cyc) @(posedge core_clk);
    ok = ok && local_txd === 1'b1;
  endtask : get_char
  // one packet byte; commands are meant unicast with a single byte
  task automatic ota_send(input logic [7:0] d, input logic uni, input logic [7:0] len);
    ota_in <= {1'b1, uni, len, d};
    @(posedge core_clk);
    ota_in <= '0;
    repeat (3) @(posedge core_clk);
  endtask : ota_send
endmodule : host_model
`default_nettype wire

// *** tb/boot_menu_command_uart_bench.sv ***
// boot_menu_command_uart_bench: self-checking bench with apb master
// assumes host_model as far side and shortened slow bit and nak bases
`timescale 1ns/1ps
`default_nettype none
module boot_menu_command_uart_bench
  import boot_menu_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst, psel, penable, pwrite, pready, pslverr, local_rxd, local_txd;
  logic radio_rxd, radio_txd, ota_tx_valid, ota_tx_ready, dl_active, dl_from_ota;
  logic dl_byte_valid, run_app, ok, e;
  logic [7:0] paddr, ota_tx_byte, dl_byte, c;
  logic [7:0] dl_seen = 8'h00;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] seed = 32'hF4E3;
  logic [39:0] dl_timeout;
  ota_cmd_type ota_in;
  logic [7:0] exp_q[$];
  logic rq[$];
  logic lq[$];
  int failures = 0;
  int total_checks = 0;
  always #2 core_clk = ~core_clk;
  boot_menu_command_uart #(.SLOW_DIV(400), .LOCAL_BASE(50), .OTA_BASE(80))
    i_boot_menu_command_uart (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .local_rxd, .local_txd, .radio_rxd,
    .radio_txd, .ota_in, .ota_tx_valid, .ota_tx_byte, .ota_tx_ready, .dl_active,
    .dl_from_ota, .dl_byte_valid, .dl_byte, .dl_timeout, .run_app);
  host_model i_host_model (.core_clk, .local_rxd, .local_txd, .ota_in,
    .ota_tx_valid, .ota_tx_byte, .ota_tx_ready);
  // the sender byte is a one-cycle pulse, so catch it here
  always @(posedge core_clk) if (dl_byte_valid === 1'b1) dl_seen <= dl_byte;
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // compares radio response bytes with the expected text, in order
  task automatic drain;
    int n;
    n = 0;
    while (i_host_model.q.size() < exp_q.size() && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 5000) begin
      failures++;
      wrap_up();
    end
    foreach (exp_q[i]) chk(i_host_model.q[i], exp_q[i]);
    exp_q.delete();
    i_host_model.q.delete();
  endtask : drain
  task automatic push_s(input string s);
    for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
  endtask : push_s
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // ----------------------------------------
  // apb master: setup, then access until pready
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    e = pslverr;
    if (n >= 50) begin
      failures++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] m, x, input logic er);
    apb(1'b0, a, 32'h0);
    chk(rd & m, x);
    chk(e, er);
  endtask : reg_chk
  task automatic ota(input logic [7:0] d);
    i_host_model.ota_send(d, 1'b1, 8'h01);
  endtask : ota
  task automatic do_reset;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    i_host_model.q.delete();
  endtask : do_reset
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    radio_rxd = 1'b1;
    do_reset();
    reg_chk(REG_CAPS, 32'hFFFF, 32'h8040, 1'b0);
    reg_chk(8'h18, 32'hFFFFFFFF, 32'h0, 1'b1);
    reg_chk(REG_STATUS, 32'h2FF, 32'h0, 1'b0);
    ota(CMD_APPVER);
    push_s("Unkown\015\012");
    drain();
    seed = xs(seed);
    apb(1'b1, REG_APPVER, seed);
    apb(1'b1, REG_CONFIG, 32'h10);
    ota(CMD_APPVER);
    for (int i = 0; i < 4; i++) exp_q.push_back(seed[8*i+:8]);
    drain();
    i_host_model.slow = 1'b0;
    ota(CMD_BLVER);
    push_s("BL032-0A0-001_064\015\012");
    drain();
    i_host_model.slow = 1'b1;
    i_host_model.ota_send(CMD_BLVER, 1'b0, 8'h01);
    i_host_model.ota_send(CMD_BLVER, 1'b1, 8'h02);
    repeat (200) @(posedge core_clk);
    chk(i_host_model.q.size(), 0);
    ota(CHR_CR);
    push_s("\015\012B=bypass F=update T=timeout A=app V=boot\015\012>");
    drain();
    ota(CMD_BYPASS);
    repeat (20) @(posedge core_clk);
    reg_chk(REG_STATUS, 32'hFF, 32'h0, 1'b0);
    ota(CMD_TIMEOUT);
    ota(CHR_ZERO + 8'h03);
    reg_chk(REG_TIMEOUT, 32'hF, 32'h3, 1'b0);
    ota(CMD_UPDATE);
    push_s("C");
    drain();
    chk(dl_from_ota, 1'b1);
    chk(dl_timeout, 40'd640);
    ota(8'h5A);
    repeat (4) @(posedge core_clk);
    chk({dl_active, dl_seen}, 9'h15A);
    apb(1'b1, REG_EVENT, 32'h1);
    repeat (4) @(posedge core_clk);
    chk(dl_timeout, 40'd1280);
    apb(1'b1, REG_EVENT, 32'h4);
    repeat (4) @(posedge core_clk);
    chk(run_app, 1'b1);
    do_reset();
    chk(run_app, 1'b0);
    i_host_model.put_char(8'h00, 2600);
    repeat (6000) @(posedge core_clk);
    reg_chk(REG_STATUS, 32'h600, 32'h600, 1'b0);
    apb(1'b1, REG_EVENT, 32'h8);
    reg_chk(REG_STATUS, 32'h400, 32'h0, 1'b0);
    apb(1'b1, REG_CONFIG, 32'hB);
    i_host_model.put_char(CMD_UPDATE, 400);
    i_host_model.get_char(c, ok, 400);
    chk({ok, c}, {1'b1, CHR_C});
    chk({dl_from_ota, dl_timeout}, 41'd50);
    do_reset();
    i_host_model.put_char(CMD_BYPASS, 2170);
    repeat (20) @(posedge core_clk);
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      radio_rxd <= seed[0];
      i_host_model.local_rxd <= seed[1];
      rq.push_back(seed[0]);
      lq.push_back(seed[1]);
      @(posedge core_clk);
      if (i >= 3) chk({local_txd, radio_txd}, {rq[i-3], lq[i-3]});
    end
    reg_chk(REG_STATUS, 32'hFF, 32'h5, 1'b0);
    wrap_up();
  end
endmodule : boot_menu_command_uart_bench
`default_nettype wire
